// ==== src/ptc_pkg.sv ====
// Purpose: Shared constants and divide table for the periodic tick counter.
// Assumes: Registers sit on classic Wishbone, one aligned 32-bit word each.
// Notes:   Only the low byte of each word is used; upper bits read as zero.
// What this block does
// R01 - Flag in bit 7 sets on the prescaler pulse after the count reaches the wrap limit.
// R02 - Writing one to the flag clears it and its request; zero does nothing.
// R03 - Source select 00 low-power osc, 01 external ref, 1x internal ref.
// R04 - Writing a different source select clears prescaler and count.
// R05 - Interrupt request is flag AND enable bit 4; else software polls.
// R06 - Divider select bits 3..0; zero switches the prescaler off.
// R07 - Writing a different divider select clears prescaler and count.
// R08 - Source low bit zero: codes 1..15 divide 8,32,...,1024,1,2,4,10,16,100,500,1000.
// R09 - Source low bit one: codes 1..7 divide 1024 up to 65536, codes 8..15 divide 1000 up to 200000.
// R10 - Count register reads the live count; writes are ignored.
// R11 - Reset clears the count.
// R12 - Any wrap limit write clears prescaler and count.
// R13 - On match the count returns to zero and the flag sets.
// R14 - With wrap limit zero the flag sets on every prescaler pulse.
// R15 - Reset clears the wrap limit.
// R16 - Software should enable a source before selecting it.
// R17 - Flag sets on the same tick the count wraps to zero.
// R18 - Counting freezes during debug halt and resumes from held value.
// R19 - Reset clears every status/control field.
// R20 - Each prescaler pulse advances the count while divider select is non-zero.
package ptc_pkg;

  localparam logic [3:0]  ptc_off_status_control = 4'h0;
  localparam logic [3:0]  ptc_off_count_value    = 4'h4;
  localparam logic [3:0]  ptc_off_wrap_limit     = 4'h8;

  localparam int          ptc_pos_match_flag     = 7;
  localparam int          ptc_pos_source_hi      = 6;
  localparam int          ptc_pos_source_lo      = 5;
  localparam int          ptc_pos_irq_enable     = 4;
  localparam int          ptc_pos_divider_hi     = 3;

  localparam logic [7:0]  ptc_rst_status_control = 8'h00;
  localparam logic [7:0]  ptc_rst_count_value    = 8'h00;
  localparam logic [7:0]  ptc_rst_wrap_limit     = 8'h00;

  localparam int          ptc_div_width          = 18;

  // Divide ratio for a divider code; zero means the prescaler is off.
  function automatic logic [17:0] ptc_divide_ratio(input logic [3:0] code,
                                                   input logic       src_lo);
    logic [17:0] r;
    r = 18'h00000;
    if (!src_lo) begin
      case (code)
        4'h1: r = 18'h00008;
        4'h2: r = 18'h00020;
        4'h3: r = 18'h00040;
        4'h4: r = 18'h00080;
        4'h5: r = 18'h00100;
        4'h6: r = 18'h00200;
        4'h7: r = 18'h00400;
        4'h8: r = 18'h00001;
        4'h9: r = 18'h00002;
        4'hA: r = 18'h00004;
        4'hB: r = 18'h0000A;
        4'hC: r = 18'h00010;
        4'hD: r = 18'h00064;
        4'hE: r = 18'h001F4;
        4'hF: r = 18'h003E8;
        default: r = 18'h00000;
      endcase
    end else begin
      case (code)
        4'h1: r = 18'h00400;
        4'h2: r = 18'h00800;
        4'h3: r = 18'h01000;
        4'h4: r = 18'h02000;
        4'h5: r = 18'h04000;
        4'h6: r = 18'h08000;
        4'h7: r = 18'h10000;
        4'h8: r = 18'h003E8;
        4'h9: r = 18'h007D0;
        4'hA: r = 18'h01388;
        4'hB: r = 18'h02710;
        4'hC: r = 18'h04E20;
        4'hD: r = 18'h0C350;
        4'hE: r = 18'h186A0;
        4'hF: r = 18'h30D40;
        default: r = 18'h00000;
      endcase
    end
    return r;
  endfunction

endpackage

// ==== src/ptc_prescaler.sv ====
// Purpose: Divides the selected source tick stream by a table ratio.
// Assumes: src_tick is a one-cycle enable pulse from the chosen source.
// Notes:   A ratio of zero holds the prescaler at zero with no output.
`timescale 1ns/10ps
module ptc_prescaler (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Control
  input  wire logic        src_tick,
  input  wire logic        hold,
  input  wire logic        clear,
  input  wire logic [17:0] ratio,
  // Output
  output      logic        pulse
);
  typedef struct packed {
    logic [17:0] cnt;
    logic        pulse;
  } ptc_pre_state_t;

  ptc_pre_state_t state;
  ptc_pre_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.pulse = 1'b0;
    if (clear || ratio == 18'h00000) begin
      next_state.cnt = 18'h00000;                         // R06
    end else if (src_tick && !hold) begin                 // R18
      if (state.cnt >= ratio - 18'h00001) begin
        next_state.cnt = 18'h00000;
        next_state.pulse = 1'b1;
      end else begin
        next_state.cnt = state.cnt + 18'h00001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pulse = state.pulse;
endmodule

// ==== src/ptc_wb_slave.sv ====
// Purpose: Classic Wishbone slave front end for the tick counter registers.
// Assumes: Master holds the request until it samples ack high.
// Notes:   Ack comes one cycle after the request; wr_commit marks the acked edge.
`timescale 1ns/10ps
module ptc_wb_slave (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  output      logic        wb_ack_o,
  // Register side
  input  wire logic [7:0]  rd_byte,
  output      logic        wr_commit,
  output      logic        rd_valid
);
  typedef struct packed {
    logic ack;
  } ptc_wb_state_t;

  ptc_wb_state_t state;
  ptc_wb_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.ack = wb_cyc_i && wb_stb_i && !state.ack;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign wb_ack_o  = state.ack;
  assign wr_commit = state.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign rd_valid  = wb_cyc_i && wb_stb_i && !wb_we_i && !state.ack && (rd_byte == rd_byte);
endmodule

// ==== src/ptc_top.sv ====
// Purpose: Periodic tick counter with prescaler, wrap limit and match flag.
// Assumes: Source clocks arrive as one-cycle enables synchronous to clock.
// Notes:   Registers at byte offsets 0x0, 0x4, 0x8 on classic Wishbone.
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module ptc_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  // Source tick enables
  input  wire logic        low_power_osc_clock,
  input  wire logic        external_ref_clock,
  input  wire logic        internal_ref_clock,
  // Debug and request
  input  wire logic        debug_halt,
  output      logic        tick_irq
);
  typedef struct packed {
    logic       tick_match_flag;
    logic [1:0] tick_source_select;
    logic       tick_irq_enable;
    logic [3:0] tick_divider_select;
    logic [7:0] tick_count_value;
    logic [7:0] tick_wrap_limit;
    logic [7:0] rd_data;
  } ptc_state_t;

  ptc_state_t  state;
  ptc_state_t  next_state;
  logic        wr_commit;
  logic        rd_valid;
  logic        pre_pulse;
  logic        src_tick;
  logic        pre_clear;
  logic [17:0] ratio;
  logic [7:0]  sc_byte;
  logic [7:0]  rd_byte;
  logic        wr_sc;
  logic        wr_limit;

  assign sc_byte = {state.tick_match_flag, state.tick_source_select,
                    state.tick_irq_enable, state.tick_divider_select};

  always_comb begin
    case (wb_adr_i)
      ptc_pkg::ptc_off_status_control: rd_byte = sc_byte;
      ptc_pkg::ptc_off_count_value:    rd_byte = state.tick_count_value;    // R10
      ptc_pkg::ptc_off_wrap_limit:     rd_byte = state.tick_wrap_limit;
      default:                         rd_byte = 8'h00;
    endcase
  end

  ptc_wb_slave u_wb (
    .clock     (clock),
    .srst      (srst),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_sel_i  (wb_sel_i),
    .wb_ack_o  (wb_ack_o),
    .rd_byte   (rd_byte),
    .wr_commit (wr_commit),
    .rd_valid  (rd_valid)
  );

  assign wr_sc    = wr_commit && wb_adr_i == ptc_pkg::ptc_off_status_control;
  assign wr_limit = wr_commit && wb_adr_i == ptc_pkg::ptc_off_wrap_limit;

  always_comb begin
    if (state.tick_source_select[ptc_pkg::ptc_pos_source_hi - 5]) begin
      src_tick = internal_ref_clock;                                       // R03
    end else if (state.tick_source_select[0]) begin
      src_tick = external_ref_clock;                                       // R03
    end else begin
      src_tick = low_power_osc_clock;                                      // R03
    end
  end

  // R08 R09
  assign ratio = ptc_pkg::ptc_divide_ratio(state.tick_divider_select,
                                           state.tick_source_select[0]);

  // Any change of source or divider, or a limit write, restarts the chain.
  assign pre_clear = wr_limit ||                                           // R12
                     (wr_sc && wb_dat_i[6:5] != state.tick_source_select) ||   // R04
                     (wr_sc && wb_dat_i[3:0] != state.tick_divider_select);    // R07

  ptc_prescaler u_pre (
    .clock    (clock),
    .srst     (srst),
    .src_tick (src_tick),
    .hold     (debug_halt),
    .clear    (pre_clear),
    .ratio    (ratio),
    .pulse    (pre_pulse)
  );

  always_comb begin
    next_state = state;
    if (rd_valid) begin
      next_state.rd_data = rd_byte;
    end
    if (wr_sc) begin
      next_state.tick_source_select  = wb_dat_i[6:5];
      next_state.tick_irq_enable     = wb_dat_i[ptc_pkg::ptc_pos_irq_enable];
      next_state.tick_divider_select = wb_dat_i[ptc_pkg::ptc_pos_divider_hi:0];
      if (wb_dat_i[ptc_pkg::ptc_pos_match_flag]) begin
        next_state.tick_match_flag = 1'b0;                                 // R02
      end
    end
    if (wr_limit) begin
      next_state.tick_wrap_limit = wb_dat_i[7:0];
    end
    if (pre_clear) begin
      next_state.tick_count_value = 8'h00;                                 // R04 R07 R12
    end else if (pre_pulse && !debug_halt &&
                 state.tick_divider_select != 4'h0) begin                  // R20 R18
      if (state.tick_count_value == state.tick_wrap_limit) begin
        next_state.tick_count_value = 8'h00;                               // R13 R14
        next_state.tick_match_flag  = 1'b1;                                // R01 R17
      end else begin
        next_state.tick_count_value = state.tick_count_value + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      {state.tick_match_flag, state.tick_source_select,
       state.tick_irq_enable, state.tick_divider_select} <=
        ptc_pkg::ptc_rst_status_control;                                   // R19
      state.tick_count_value <= ptc_pkg::ptc_rst_count_value;              // R11
      state.tick_wrap_limit  <= ptc_pkg::ptc_rst_wrap_limit;               // R15
      state.rd_data          <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  assign wb_dat_o = {24'h000000, state.rd_data};
  assign tick_irq = state.tick_match_flag && state.tick_irq_enable;        // R05
endmodule

// ==== tb/ptc_properties.sv ====
// Purpose: Port-level checks for the periodic tick counter.
// Assumes: Ack follows each request by one cycle.
// Notes:   Bound to every ptc_top instance.
`timescale 1ns/10ps
module ptc_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic        debug_halt,
  input wire logic        tick_irq
);
  logic wr0;
  assign wr0 = wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack unasked");
  a_irq_reset: assert property ($fell(srst) |-> !tick_irq)
    else $error("irq after reset");
  a_irq_off: assert property (wr0 && !wb_dat_i[4] |=> !tick_irq)
    else $error("irq while disabled");
  a_irq_keep: assert property (wr0 && wb_dat_i[4] && !wb_dat_i[7] && tick_irq |=> tick_irq)
    else $error("irq lost on zero write");
  a_irq_hold: assert property (tick_irq && !wr0 |=> tick_irq)
    else $error("irq dropped alone");
  a_halt_quiet: assert property (debug_halt[*3] ##0 (!tick_irq && !wb_ack_o) |=> !tick_irq)
    else $error("irq during halt");
  a_dat_hold: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o))
    else $error("read data moved");
  c_irq: cover property ($rose(tick_irq));
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_halt: cover property (debug_halt[*3]);
endmodule
bind ptc_top ptc_props i_ptc_props (.clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .debug_halt, .tick_irq);

// ==== tb/tb.sv ====
// Purpose: Register-level regression of the periodic tick counter.
// Assumes: The bench waits for ack rather than counting cycles.
// Notes:   Source clocks are driven as one-cycle enables.
`timescale 1ns/10ps
module tb;
  logic        clock, srst, cyc, stb, we, halt, ack, irq;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat;
  logic [2:0]  src;
  int          fails, checks_done, cyc_n;
  ptc_top i_ptc_top (.clock, .srst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .low_power_osc_clock(src[0]), .external_ref_clock(src[1]),
    .internal_ref_clock(src[2]), .debug_halt(halt), .tick_irq(irq));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] m, output logic [31:0] q);
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= m;
    wdat <= {24'h000000, d};
    do @(posedge clock); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, 4'hF, q);
    chk(n, q, {24'h000000, e});
  endtask
  task automatic tick(input int k, input int n);
    repeat (n) begin
      @(posedge clock);
      src[k] <= 1'b1;
      @(posedge clock);
      src[k] <= 1'b0;
    end
    repeat (4) @(posedge clock);
  endtask
  initial begin
    logic [31:0] dummy;
    {cyc, stb, we, halt} = 4'h0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h00000000;
    src = 3'h0;
    srst = 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    rc("ctrl", 4'h0, 8'h00);
    rc("count", 4'h4, 8'h00);
    rc("limit", 4'h8, 8'h00);
    rc("unmapped", 4'hC, 8'h00);
    chk("irq", 32'(irq), 32'h00000000);
    $display("reset test done");
    acc(1'b1, 4'h8, 8'h77, 4'hE, dummy);
    rc("limit", 4'h8, 8'h00);
    wr(4'h8, 8'h03);
    rc("limit", 4'h8, 8'h03);
    wr(4'h4, 8'hFF);
    rc("count", 4'h4, 8'h00);
    wr(4'h0, 8'h18);
    tick(0, 2);
    rc("count", 4'h4, 8'h02);
    tick(1, 1);
    rc("count", 4'h4, 8'h02);
    @(posedge clock);
    halt <= 1'b1;
    tick(0, 3);
    rc("count", 4'h4, 8'h02);
    halt <= 1'b0;
    tick(0, 1);
    rc("ctrl", 4'h0, 8'h18);
    tick(0, 1);
    rc("count", 4'h4, 8'h00);
    rc("ctrl", 4'h0, 8'h98);
    chk("irq", 32'(irq), 32'h00000001);
    tick(0, 1);
    wr(4'h0, 8'h18);
    rc("count", 4'h4, 8'h01);
    rc("ctrl", 4'h0, 8'h98);
    wr(4'h0, 8'h98);
    rc("ctrl", 4'h0, 8'h18);
    chk("irq", 32'(irq), 32'h00000000);
    $display("count test done");
    wr(4'h8, 8'hFF);
    rc("count", 4'h4, 8'h00);
    wr(4'h0, 8'h11);
    tick(0, 7);
    rc("count", 4'h4, 8'h00);
    tick(0, 1);
    rc("count", 4'h4, 8'h01);
    wr(4'h0, 8'h31);
    rc("count", 4'h4, 8'h00);
    wr(4'h8, 8'h00);
    tick(1, 1023);
    rc("ctrl", 4'h0, 8'h31);
    tick(1, 1);
    rc("ctrl", 4'h0, 8'hB1);
    chk("irq", 32'(irq), 32'h00000001);
    wr(4'h0, 8'hC8);
    tick(2, 1);
    rc("ctrl", 4'h0, 8'hC8);
    tick(2, 1);
    rc("count", 4'h4, 8'h00);
    rc("ctrl", 4'h0, 8'hC8);
    chk("irq", 32'(irq), 32'h00000000);
    wr(4'h0, 8'hE8);
    tick(2, 999);
    rc("ctrl", 4'h0, 8'h68);
    wr(4'h0, 8'h60);
    tick(2, 3);
    rc("ctrl", 4'h0, 8'h60);
    $display("divider test done");
    end_sim();
  end
endmodule
